// >>> rtl/bpr_params.svh
// constants for the bridge data parity reporting block
//
// Behaviour
// R1: the upstream-side data-parity-detected bit is set only while the bridge masters the upstream bus, its response enable is on, and an error was signalled or detected there.
// R2: that bit sets for upstream reads, posted writes and delayed writes with the error on the upstream bus and enable on, never otherwise.
// R3: the downstream-side data-parity-detected bit is set only while the bridge masters the downstream bus, its response enable is on, and an error was signalled or detected there.
// R4: that bit sets for downstream reads, posted writes and delayed writes with the error on the downstream bus and enable on, never otherwise.
// R5: the upstream parity error pin is driven only as write target or read initiator on the upstream bus with the upstream enable on.
// R6: the upstream pin is pulled low for upstream-bus errors on upstream reads and downstream posted or delayed writes with enable on, else it stays high.
// R7: an error signalled by the downstream target while completing a downstream delayed write is passed back on the upstream pin if no upstream error was seen and both enables are on.
// R8: the upstream pin fires on a bridge-detected upstream data parity error or on that delayed write completion error.
// R9: the downstream parity error pin is driven only as write target or read initiator on the downstream bus with the downstream enable on.
// R10: the downstream pin fires on downstream-bus errors and on an upstream pin error while completing an upstream delayed write;
// the code fires it for downstream-bus errors only on downstream reads and upstream posted or delayed writes.
// R11: the detected bits stay set until software writes one to them, and reset clears them.
`ifndef BPR_PARAMS_SVH
`define BPR_PARAMS_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define BPR_ADDR_W 8
`define BPR_OFS_CONTROL 8'h00
`define BPR_OFS_STATUS 8'h04
`define BPR_OFS_LIVE 8'h08

// -----------------------------------------------------------------
// fields
// -----------------------------------------------------------------
`define BPR_BIT_UP 0
`define BPR_BIT_DN 1
`define BPR_CONTROL_RST 2'h0
`define BPR_STATUS_RST 2'h0

// -----------------------------------------------------------------
// bus answers and timing
// -----------------------------------------------------------------
`define BPR_RESP_OKAY 2'h0
`define BPR_RESP_SLVERR 2'h2
`define BPR_PCI_CLK_NS 25
`define BPR_CLK_NS 25
`define BPR_PERR_LOW_CYCLES ((`BPR_PCI_CLK_NS + `BPR_CLK_NS - 1) / `BPR_CLK_NS)

`endif

// >>> rtl/bpr_pkg.sv
// types of the bridge data parity reporting block
package bpr_pkg;

   typedef enum logic [1:0] {
      BPR_READ,
      BPR_POSTED_WR,
      BPR_DELAYED_WR
   } bpr_kind_t;

   typedef enum logic {BPR_DOWN, BPR_UP} bpr_dir_t;
   typedef enum logic {BPR_BUS_UP, BPR_BUS_DN} bpr_bus_t;

   // a data parity error seen on one bus
   typedef struct packed {
      logic valid;
      bpr_kind_t kind;
      bpr_dir_t dir;
      bpr_bus_t bus;
      logic init_err;
   } bpr_evt_t;

   // what the bridge does on its side as bus master of a write
   typedef struct packed {
      logic active;
      bpr_kind_t kind;
      bpr_dir_t dir;
      logic init_err;
   } bpr_ctx_t;

   typedef struct packed {
      logic set_up_dp;
      logic set_dn_dp;
      logic drive_up_perr;
      logic drive_dn_perr;
   } bpr_act_t;

   typedef enum logic [1:0] {
      BPR_PH_IDLE,
      BPR_PH_LOW,
      BPR_PH_HIGH
   } bpr_phase_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic up_en;
      logic dn_en;
      logic up_dp;
      logic dn_dp;
      bpr_phase_t up_ph;
      bpr_phase_t dn_ph;
      logic [1:0] up_cnt;
      logic [1:0] dn_cnt;
      logic up_n;
      logic up_oe;
      logic dn_n;
      logic dn_oe;
   } bpr_state_t;

endpackage

// >>> rtl/bpr_decode.sv
// maps one parity error event to status and pin actions
`timescale 1ns/1ps
`include "bpr_params.svh"
module bpr_decode (
   // event and enables
   input wire bpr_pkg::bpr_evt_t evt,
   input wire logic up_en,
   input wire logic dn_en,
   // resulting actions
   output bpr_pkg::bpr_act_t act
);

   function automatic bpr_pkg::bpr_act_t decode(
      input bpr_pkg::bpr_evt_t e,
      input logic pe,
      input logic se
   );
      bpr_pkg::bpr_act_t a;
      logic up_dir;
      logic fwd_ok;
      a = '0;
      up_dir = (e.dir == bpr_pkg::BPR_UP);
      fwd_ok = pe && se && !e.init_err;
      if (e.valid) begin
         if (e.bus == bpr_pkg::BPR_BUS_UP) begin
            // bridge masters the upstream bus only on upstream traffic
            a.set_up_dp = up_dir && pe; // [R1] [R2]
            case (e.kind)
               bpr_pkg::BPR_READ: begin
                  a.drive_up_perr = up_dir && pe; // [R5] [R6] [R8]
               end
               bpr_pkg::BPR_POSTED_WR: begin
                  a.drive_up_perr = !up_dir && pe; // [R5] [R6] [R8]
               end
               bpr_pkg::BPR_DELAYED_WR: begin
                  a.drive_up_perr = !up_dir && pe; // [R5] [R6] [R8]
                  a.drive_dn_perr = up_dir && fwd_ok; // [R10]
               end
               default: begin
                  a = '0;
               end
            endcase
         end else begin
            a.set_dn_dp = !up_dir && se; // [R3] [R4]
            case (e.kind)
               bpr_pkg::BPR_READ: begin
                  a.drive_dn_perr = !up_dir && se; // [R9] [R10]
               end
               bpr_pkg::BPR_POSTED_WR: begin
                  a.drive_dn_perr = up_dir && se; // [R9] [R10]
               end
               bpr_pkg::BPR_DELAYED_WR: begin
                  a.drive_dn_perr = up_dir && se; // [R9] [R10]
                  a.drive_up_perr = !up_dir && fwd_ok; // [R7] [R8]
               end
               default: begin
                  a = '0;
               end
            endcase
         end
      end
      return a;
   endfunction

   assign act = decode(evt, up_en, dn_en);

endmodule

// >>> rtl/bpr_top.sv
// bridge data parity reporting with an axi4-lite register slave
`timescale 1ns/1ps
`include "bpr_params.svh"
module bpr_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // parity errors found by the bridge's own checkers
   input wire bpr_pkg::bpr_evt_t det_evt,
   // bridge as master of a write on each bus
   input wire bpr_pkg::bpr_ctx_t up_ctx,
   input wire bpr_pkg::bpr_ctx_t dn_ctx,
   // upstream side parity error pin
   input wire logic upstream_side_parity_err_n_i,
   output logic upstream_side_parity_err_n_o,
   output logic upstream_side_parity_err_oe,
   // downstream side parity error pin
   input wire logic downstream_side_parity_err_n_i,
   output logic downstream_side_parity_err_n_o,
   output logic downstream_side_parity_err_oe
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == `BPR_OFS_CONTROL) || (a == `BPR_OFS_STATUS) ||
         (a == `BPR_OFS_LIVE);
   endfunction

   // pin drives low then high for one cycle before letting go, as pci asks
   function automatic bpr_pkg::bpr_phase_t next_phase(
      input bpr_pkg::bpr_phase_t ph,
      input logic [1:0] cnt,
      input logic trig
   );
      bpr_pkg::bpr_phase_t n;
      n = ph;
      if (trig) begin
         n = bpr_pkg::BPR_PH_LOW;
      end else begin
         case (ph)
            bpr_pkg::BPR_PH_LOW: begin
               if (cnt == 2'(`BPR_PERR_LOW_CYCLES - 1)) begin
                  n = bpr_pkg::BPR_PH_HIGH;
               end
            end
            bpr_pkg::BPR_PH_HIGH: begin
               n = bpr_pkg::BPR_PH_IDLE;
            end
            default: begin
               n = bpr_pkg::BPR_PH_IDLE;
            end
         endcase
      end
      return n;
   endfunction

   // -----------------------------------------------------------------
   // event decoding
   // -----------------------------------------------------------------
   bpr_pkg::bpr_state_t st;
   bpr_pkg::bpr_state_t next_st;
   bpr_pkg::bpr_evt_t up_pin_evt;
   bpr_pkg::bpr_evt_t dn_pin_evt;
   bpr_pkg::bpr_act_t det_act;
   bpr_pkg::bpr_act_t up_pin_act;
   bpr_pkg::bpr_act_t dn_pin_act;
   bpr_pkg::bpr_act_t act;
   logic wr_fire;
   logic rd_fire;
   logic [1:0] clr_dp;

   // a pin seen low while we are not driving it is the far target's report
   always_comb begin
      up_pin_evt.valid = up_ctx.active && !upstream_side_parity_err_n_i &&
         !st.up_oe; // [R1]
      up_pin_evt.kind = up_ctx.kind;
      up_pin_evt.dir = up_ctx.dir;
      up_pin_evt.bus = bpr_pkg::BPR_BUS_UP;
      up_pin_evt.init_err = up_ctx.init_err;
      dn_pin_evt.valid = dn_ctx.active && !downstream_side_parity_err_n_i &&
         !st.dn_oe; // [R3]
      dn_pin_evt.kind = dn_ctx.kind;
      dn_pin_evt.dir = dn_ctx.dir;
      dn_pin_evt.bus = bpr_pkg::BPR_BUS_DN;
      dn_pin_evt.init_err = dn_ctx.init_err;
   end

   bpr_decode u_dec_det (
      .evt(det_evt),
      .up_en(st.up_en),
      .dn_en(st.dn_en),
      .act(det_act)
   );

   bpr_decode u_dec_up (
      .evt(up_pin_evt),
      .up_en(st.up_en),
      .dn_en(st.dn_en),
      .act(up_pin_act)
   );

   bpr_decode u_dec_dn (
      .evt(dn_pin_evt),
      .up_en(st.up_en),
      .dn_en(st.dn_en),
      .act(dn_pin_act)
   );

   assign act = det_act | up_pin_act | dn_pin_act;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      wr_fire = st.aw_held && st.w_held && !st.bvalid;
      rd_fire = s_axi_arvalid && st.arready;
      clr_dp = 2'h0;
      // write address and data are taken in either order
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = addr_ok(st.awaddr) ? `BPR_RESP_OKAY :
            `BPR_RESP_SLVERR;
         if (st.wstrb[0]) begin
            if (st.awaddr == `BPR_OFS_CONTROL) begin
               next_st.up_en = st.wdata[`BPR_BIT_UP];
               next_st.dn_en = st.wdata[`BPR_BIT_DN];
            end
            if (st.awaddr == `BPR_OFS_STATUS) begin
               clr_dp = st.wdata[1:0];
            end
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      next_st.awready = !next_st.aw_held;
      next_st.wready = !next_st.w_held;
      // read: one outstanding, answered the cycle after address is taken
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = 32'h0000_0000;
         next_st.rresp = addr_ok(s_axi_araddr) ? `BPR_RESP_OKAY :
            `BPR_RESP_SLVERR;
         case (s_axi_araddr)
            `BPR_OFS_CONTROL: begin
               next_st.rdata[1:0] = {st.dn_en, st.up_en};
            end
            `BPR_OFS_STATUS: begin
               next_st.rdata[1:0] = {st.dn_dp, st.up_dp};
            end
            `BPR_OFS_LIVE: begin
               next_st.rdata[1:0] = {st.dn_oe && !st.dn_n,
                  st.up_oe && !st.up_n};
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end
      next_st.arready = !next_st.rvalid;
      // sticky detected bits; a new event beats a clear in the same cycle
      next_st.up_dp = (st.up_dp && !clr_dp[`BPR_BIT_UP]) ||
         act.set_up_dp; // [R11] [R1] [R2]
      next_st.dn_dp = (st.dn_dp && !clr_dp[`BPR_BIT_DN]) ||
         act.set_dn_dp; // [R11] [R3] [R4]
      // pin sequencers
      next_st.up_ph = next_phase(st.up_ph, st.up_cnt,
         act.drive_up_perr); // [R6] [R7] [R8]
      next_st.dn_ph = next_phase(st.dn_ph, st.dn_cnt,
         act.drive_dn_perr); // [R10]
      next_st.up_cnt = (next_st.up_ph == bpr_pkg::BPR_PH_LOW &&
         !act.drive_up_perr) ? st.up_cnt + 2'h1 : 2'h0;
      next_st.dn_cnt = (next_st.dn_ph == bpr_pkg::BPR_PH_LOW &&
         !act.drive_dn_perr) ? st.dn_cnt + 2'h1 : 2'h0;
      next_st.up_n = (next_st.up_ph != bpr_pkg::BPR_PH_LOW); // [R5]
      next_st.up_oe = (next_st.up_ph != bpr_pkg::BPR_PH_IDLE);
      next_st.dn_n = (next_st.dn_ph != bpr_pkg::BPR_PH_LOW); // [R9]
      next_st.dn_oe = (next_st.dn_ph != bpr_pkg::BPR_PH_IDLE);
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.up_en <= 1'(`BPR_CONTROL_RST >> `BPR_BIT_UP);
         st.dn_en <= 1'(`BPR_CONTROL_RST >> `BPR_BIT_DN);
         st.up_dp <= 1'(`BPR_STATUS_RST >> `BPR_BIT_UP); // [R11]
         st.dn_dp <= 1'(`BPR_STATUS_RST >> `BPR_BIT_DN); // [R11]
         st.up_n <= 1'b1;
         st.dn_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bresp = st.bresp;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_arready = st.arready;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rvalid = st.rvalid;
   assign upstream_side_parity_err_n_o = st.up_n;
   assign upstream_side_parity_err_oe = st.up_oe;
   assign downstream_side_parity_err_n_o = st.dn_n;
   assign downstream_side_parity_err_oe = st.dn_oe;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_up_dp_set: assert property ( // [R2]
      @(posedge aclk) disable iff (!aresetn)
      det_evt.valid && det_evt.bus == bpr_pkg::BPR_BUS_UP &&
      det_evt.dir == bpr_pkg::BPR_UP && st.up_en |=> st.up_dp)
      else $error("upstream detected bit not set");

   a_up_dp_cause: assert property ( // [R1]
      @(posedge aclk) disable iff (!aresetn)
      $rose(st.up_dp) |-> $past(st.up_en) && $past(act.set_up_dp))
      else $error("upstream detected bit set without cause");

   a_dn_dp_set: assert property ( // [R4]
      @(posedge aclk) disable iff (!aresetn)
      det_evt.valid && det_evt.bus == bpr_pkg::BPR_BUS_DN &&
      det_evt.dir == bpr_pkg::BPR_DOWN && st.dn_en |=> st.dn_dp)
      else $error("downstream detected bit not set");

   a_dn_dp_cause: assert property ( // [R3]
      @(posedge aclk) disable iff (!aresetn)
      $rose(st.dn_dp) |-> $past(st.dn_en))
      else $error("downstream detected bit set while disabled");

   a_dp_sticky: assert property ( // [R11]
      @(posedge aclk) disable iff (!aresetn)
      st.up_dp && !clr_dp[`BPR_BIT_UP] |=> st.up_dp [*1] ##0
      $past(st.up_dp))
      else $error("upstream detected bit dropped without clear");

   a_up_perr_en: assert property ( // [R5]
      @(posedge aclk) disable iff (!aresetn)
      $fell(st.up_n) |-> $past(st.up_en))
      else $error("upstream pin driven while disabled");

   a_up_perr_fire: assert property ( // [R6]
      @(posedge aclk) disable iff (!aresetn)
      det_evt.valid && det_evt.bus == bpr_pkg::BPR_BUS_UP &&
      det_evt.kind == bpr_pkg::BPR_READ &&
      det_evt.dir == bpr_pkg::BPR_UP && st.up_en
      |=> !st.up_n && st.up_oe)
      else $error("upstream pin not pulled low on read error");

   a_dw_pass_back: assert property ( // [R7]
      @(posedge aclk) disable iff (!aresetn)
      dn_pin_evt.valid && dn_ctx.kind == bpr_pkg::BPR_DELAYED_WR &&
      dn_ctx.dir == bpr_pkg::BPR_DOWN && !dn_ctx.init_err &&
      st.up_en && st.dn_en |=> !st.up_n)
      else $error("delayed write error not passed back upstream");

   a_up_perr_cause: assert property ( // [R8]
      @(posedge aclk) disable iff (!aresetn)
      $fell(st.up_n) |-> $past(act.drive_up_perr))
      else $error("upstream pin low without trigger");

   a_dn_perr_en: assert property ( // [R9]
      @(posedge aclk) disable iff (!aresetn)
      $fell(st.dn_n) |-> $past(st.dn_en))
      else $error("downstream pin driven while disabled");

   a_dn_perr_fwd: assert property ( // [R10]
      @(posedge aclk) disable iff (!aresetn)
      up_pin_evt.valid && up_ctx.kind == bpr_pkg::BPR_DELAYED_WR &&
      up_ctx.dir == bpr_pkg::BPR_UP && !up_ctx.init_err &&
      st.up_en && st.dn_en |=> !st.dn_n ##1 (st.dn_n || !st.dn_oe ||
      $past(act.drive_dn_perr)))
      else $error("upstream delayed write error not forwarded");

   a_perr_release: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $fell(st.up_oe) |-> $past(st.up_n, 1))
      else $error("upstream pin released while low");

   // a downstream read error is answered on the downstream pin
   a_dn_perr_fire: assert property ( // [R10]
      @(posedge aclk) disable iff (!aresetn)
      det_evt.valid && det_evt.bus == bpr_pkg::BPR_BUS_DN &&
      det_evt.kind == bpr_pkg::BPR_READ &&
      det_evt.dir == bpr_pkg::BPR_DOWN && st.dn_en
      |=> !st.dn_n && st.dn_oe)
      else $error("downstream pin not pulled low on read error");

   // as target of a posted write the bridge reports on its own bus
   a_up_pw_perr: assert property ( // [R6]
      @(posedge aclk) disable iff (!aresetn)
      det_evt.valid && det_evt.bus == bpr_pkg::BPR_BUS_UP &&
      det_evt.kind == bpr_pkg::BPR_POSTED_WR &&
      det_evt.dir == bpr_pkg::BPR_DOWN && st.up_en
      |=> !st.up_n && st.up_oe)
      else $error("upstream pin not pulled low on posted write error");

   // downstream traffic never marks the upstream detected bit
   a_up_dp_only: assert property ( // [R2]
      @(posedge aclk) disable iff (!aresetn)
      $rose(st.up_dp) |-> ($past(det_evt.valid) &&
      $past(det_evt.bus) == bpr_pkg::BPR_BUS_UP &&
      $past(det_evt.dir) == bpr_pkg::BPR_UP) ||
      ($past(up_pin_evt.valid) && $past(up_ctx.dir) == bpr_pkg::BPR_UP))
      else $error("upstream detected bit set for a refused case");

endmodule

// >>> verification/bpr_far_model.sv
// far-side model of the two parity error wires and their pull-ups
`timescale 1ns/1ps
module bpr_far_model (
   // far target reporting a data parity error, one cycle per request
   input wire logic report_up,
   input wire logic report_dn,
   // bridge side of each pin
   input wire logic up_n,
   input wire logic up_oe,
   input wire logic dn_n,
   input wire logic dn_oe,
   // resolved wire levels fed back to the bridge
   output logic up_wire,
   output logic dn_wire
);
   // the pull-up returns a released line high, never a stale low
   assign up_wire = up_oe ? up_n : ~report_up;
   assign dn_wire = dn_oe ? dn_n : ~report_dn;
endmodule

// >>> verification/tb.sv
// self-checking testbench of the bridge data parity reporting block
`timescale 1ns/1ps
module tb;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   bpr_pkg::bpr_evt_t det_evt;
   bpr_pkg::bpr_ctx_t up_ctx;
   bpr_pkg::bpr_ctx_t dn_ctx;
   logic up_wire;
   logic dn_wire;
   logic up_n_o;
   logic up_oe;
   logic dn_n_o;
   logic dn_oe;
   logic rep_up;
   logic rep_dn;
   logic [33:0] expq[$];
   int mismatches;
   int comparisons;
   int cycles;
   int i;
   integer seed;
   logic [31:0] d;
   logic [1:0] en;
   logic [1:0] k;
   logic ini, dr, bs, src, pu, pd, su, sd;

   bpr_top i_bpr_top (
      .aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .det_evt, .up_ctx, .dn_ctx,
      .upstream_side_parity_err_n_i(up_wire),
      .upstream_side_parity_err_n_o(up_n_o),
      .upstream_side_parity_err_oe(up_oe),
      .downstream_side_parity_err_n_i(dn_wire),
      .downstream_side_parity_err_n_o(dn_n_o),
      .downstream_side_parity_err_oe(dn_oe)
   );

   bpr_far_model i_bpr_far_model (
      .report_up(rep_up), .report_dn(rep_dn),
      .up_n(up_n_o), .up_oe(up_oe), .dn_n(dn_n_o), .dn_oe(dn_oe),
      .up_wire(up_wire), .dn_wire(dn_wire)
   );

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // -----------------------------------------------------------------
   // comparison and closing
   // -----------------------------------------------------------------
   task check(input string n, input logic [33:0] seen, input logic [33:0] e);
      comparisons++;
      if (seen !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, seen);
      end
   endtask

   task summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task pins(input logic [1:0] eu, input logic [1:0] ed);
      check("up_pin", 34'({up_oe, up_n_o}), 34'(eu));
      check("dn_pin", 34'({dn_oe, dn_n_o}), 34'(ed));
   endtask

   // -----------------------------------------------------------------
   // register bus master
   // -----------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
           input logic [1:0] er);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (!ad && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", 34'(s_axi_bresp), 34'(er));
   endtask

   // expectation is queued here and compared by the read monitor
   task rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         check("read", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
      end
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      seed = 74;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready, rep_up, rep_dn} = '0;
      det_evt = '0;
      up_ctx = '0;
      dn_ctx = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      pins(2'b01, 2'b01);
      rd(8'h00, 34'h0);
      rd(8'h04, 34'h0);
      rd(8'h08, 34'h0);
      rd(8'h0C, {2'h2, 32'h0});
      wr(8'h0C, 32'h3, 4'hF, 2'h2);
      // every kind, direction, bus, enable pair, blocking flag and source
      for (i = 0; i < 192; i++) begin
         en = i[1:0];
         ini = i[2];
         dr = i[3];
         bs = i[4];
         src = i[5];
         k = i[7:6];
         d = $random(seed);
         wr(8'h00, {d[31:2], en}, 4'hF, 2'h0);
         rd(8'h00, {32'h0, en});
         pu = en[0] & ((~bs & (k == 2'h0 ? dr : ~dr))
              | (bs & k == 2'h2 & ~dr & en[1] & ~ini));
         pd = en[1] & ((bs & (k == 2'h0 ? ~dr : dr))
              | (~bs & k == 2'h2 & dr & en[0] & ~ini));
         su = ~bs & dr & en[0];
         sd = bs & ~dr & en[1];
         @(posedge aclk);
         if (!src) det_evt <= {1'b1, k, dr, bs, ini};
         else if (!bs) begin
            up_ctx <= {1'b1, k, dr, ini};
            rep_up <= 1'b1;
         end else begin
            dn_ctx <= {1'b1, k, dr, ini};
            rep_dn <= 1'b1;
         end
         @(posedge aclk);
         det_evt <= '0;
         up_ctx <= '0;
         dn_ctx <= '0;
         rep_up <= 1'b0;
         rep_dn <= 1'b0;
         #1 pins({pu, ~pu}, {pd, ~pd});
         @(posedge aclk);
         #1 pins({pu, 1'b1}, {pd, 1'b1});
         @(posedge aclk);
         #1 pins(2'b01, 2'b01);
         rd(8'h04, {32'h0, sd, su});
         wr(8'h04, 32'h3, 4'hF, 2'h0);
      end
      // both bits set, the upstream bit cleared, then a write with no strobes leaves the downstream bit set
      wr(8'h00, 32'h3, 4'hF, 2'h0);
      @(posedge aclk) det_evt <= {1'b1, 2'h0, 1'b1, 1'b0, 1'b0};
      @(posedge aclk) det_evt <= {1'b1, 2'h0, 1'b0, 1'b1, 1'b0};
      // the read is taken while the downstream pin is in its low cycle
      fork
         rd(8'h08, 34'h2);
         @(posedge aclk) det_evt <= '0;
      join
      rd(8'h04, 34'h3);
      wr(8'h04, 32'h1, 4'hF, 2'h0);
      rd(8'h04, 34'h2);
      wr(8'h04, 32'h2, 4'h0, 2'h0);
      rd(8'h04, 34'h2);
      // a reset in mid-run drops the sticky bit and the enables
      @(posedge aclk) aresetn <= 1'b0;
      @(posedge aclk) aresetn <= 1'b1;
      rd(8'h04, 34'h0);
      rd(8'h00, 34'h0);
      summarize();
   end
endmodule
